// ==== hw/dic_ctrl.sv ====
// DRAM interface controller: address multiplexing, short and long pitch
// access, precharge, wait insertion, byte strobes, page mode and row hold.
// Assumes request inputs synchronous to clk and an AXI4-Lite master.
//
// Functional notes
// - Space enable makes area accesses drive DRAM
// - Mux enable sends row then column
// - Nine/ten shift: row from bit 9/10
// - Eight shift: row bits 23..8, column unchanged
// - Pitch bit picks one or two column states
// - Separate pitch for cpu/dma reads/writes
// - Short pitch column strobe high 50 or 35%
// - Precharge lasts one or two states
// - Short pitch ignores wait input entirely
// - Long pitch samples wait before second state
// - Long cpu read pitch adds refresh wait states
// - Wide space: dual strobe or dual write
// - Byte space: lower strobes only
// - Burst enable: page access on row match
// - Short page: one-state columns, no wait
// - Short page: idle cycle before same-row write
// - Dma write gets idle cycle only as a short page write
// - Long page: second column state repeats on wait
// - Bursts survive a change of bus master
// - Hold bit keeps row strobe low elsewhere
// - Refresh always raises the row strobe
// - Without hold, other access closes the row
//
// Local design decisions: register access over AXI4-Lite and the address map.
`include "dic_regs.svh"
module dic_ctrl #(
    parameter int TICKS = `DIC_TICKS_PER_STATE
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [7:0] s_axi_awaddr, // Write byte address
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    output logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    input wire logic [7:0] s_axi_araddr, // Read byte address
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    input wire logic reqValid, // DRAM access request
    output logic reqReady, // Request can be taken this cycle
    input wire logic [23:0] reqAddr, // Byte address of the access
    input wire logic reqWrite, // Access is a write
    input wire logic reqDma, // Access comes from the DMA unit
    input wire logic reqWide, // Area is 16-bit wide
    input wire logic reqUpper, // Upper byte selected
    input wire logic reqLower, // Lower byte selected
    output logic reqDone, // Access finished, one cycle
    input wire logic refreshReq, // Refresh wanted, held until ack
    output logic refreshAck, // Refresh finished, one cycle
    input wire logic otherAccess, // Another space is being accessed
    input wire logic waitN, // External wait, active low
    output logic [21:0] dramAddr, // Multiplexed address pins
    output logic rasN, // Row strobe, active low
    output logic casHiN, // Upper column strobe, active low
    output logic casLoN, // Lower column strobe, active low
    output logic wrHiN, // Upper write strobe, active low
    output logic wrLoN // Lower write strobe, active low
);
    dic_pkg::dic_st_t cur; // Registered state
    dic_pkg::dic_st_t next_cur; // Next state
    dic_phase_if ph(); // Phase carrier

    logic spaceEn; // Area is DRAM
    logic burstEn; // Page mode allowed
    logic holdEn; // Row strobe held across other spaces
    logic [1:0] shiftSel; // Row shift select
    logic rowHit; // Request falls in the open row
    logic accept; // Request taken now
    logic reqLong; // Pitch of the pending request
    logic colState; // A column state is running
    logic casOn; // Column strobe driven low
    logic [7:0] highTicks; // Strobe high part of a short column

    // Phase divider shared by every bus state
    dic_phase_gen #(.TICKS(TICKS)) u_phase (
        .clk(clk),
        .reset_n(reset_n),
        .ph(ph)
    );

    // Row address for a given shift select
    function automatic logic [15:0] rowOf(input logic [23:0] a, input logic [1:0] sh);
        rowOf = 16'(a >> (`DIC_ROW_BASE_SHIFT + int'(sh)));
    endfunction

    // Pitch bit that applies to one kind of cycle
    function automatic logic pitchOf(input logic [5:0] p, input logic wr, input logic dma);
        if (dma) begin
            pitchOf = wr ? p[`DIC_PITCH_DMA_WR] : p[`DIC_PITCH_DMA_RD];
        end else begin
            pitchOf = wr ? p[`DIC_PITCH_CPU_WR] : p[`DIC_PITCH_CPU_RD];
        end
    endfunction

    // Merge written bytes into a register image
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] strb);
        mergeBytes = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                mergeBytes[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // Configuration fields
    assign spaceEn = cur.cfg[`DIC_CFG_SPACE_EN];
    assign burstEn = cur.cfg[`DIC_CFG_BURST];
    assign holdEn = cur.cfg[`DIC_CFG_HOLD];
    assign shiftSel = {cur.cfg[`DIC_CFG_SHIFT_HI], cur.cfg[`DIC_CFG_SHIFT_LO]};
    assign reqLong = pitchOf(cur.pitch, reqWrite, reqDma);

    // Page hit only with burst on; the bus master plays no part
    assign rowHit = burstEn && rowOf(reqAddr, shiftSel) == cur.rowLatch;

    // Take a request only when no refresh and no mismatched open row
    assign reqReady = cur.state == dic_pkg::IDLE && !refreshReq && spaceEn
                      && !(cur.rowOpen && !rowHit);
    assign accept = reqValid && reqReady;

    // Column strobe high ticks for the selected duty
    assign highTicks = cur.cfg[`DIC_CFG_DUTY] ? 8'(TICKS * `DIC_DUTY_NARROW / 100)
                                               : 8'(TICKS * `DIC_DUTY_WIDE / 100);

    // Sequencer and register bus next-state logic
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.refAck = 1'b0;
        case (cur.state)
            dic_pkg::IDLE: begin
                if (refreshReq) begin
                    // Refresh first closes any held row
                    if (cur.rowOpen) begin
                        next_cur.rowOpen = 1'b0;
                        next_cur.prechLeft = cur.cfg[`DIC_CFG_PRECH];
                        next_cur.state = dic_pkg::PRECH;
                    end else begin
                        next_cur.state = dic_pkg::REFC;
                    end
                end else if (reqValid && spaceEn && cur.rowOpen && !rowHit) begin
                    // Wrong row: precharge, then the request is retried in full
                    next_cur.rowOpen = 1'b0;
                    next_cur.prechLeft = cur.cfg[`DIC_CFG_PRECH];
                    next_cur.state = dic_pkg::PRECH;
                end else if (accept) begin
                    next_cur.addrLat = reqAddr;
                    next_cur.isWrite = reqWrite;
                    next_cur.isWide = reqWide;
                    next_cur.useUpper = reqUpper;
                    next_cur.useLower = reqLower;
                    next_cur.longP = reqLong;
                    if (cur.rowOpen) begin
                        // Short page write always follows an access in this row
                        if (!reqLong && reqWrite) begin
                            next_cur.state = dic_pkg::SILENT;
                        end else begin
                            next_cur.state = dic_pkg::COL1;
                        end
                    end else begin
                        next_cur.rowOpen = 1'b1;
                        next_cur.rowLatch = rowOf(reqAddr, shiftSel);
                        next_cur.state = dic_pkg::ROW;
                    end
                end else if (cur.rowOpen && ((otherAccess && !holdEn) || !spaceEn || !burstEn)) begin
                    // Row strobe goes high when the bus leaves for another space without hold, or when burst or space is off
                    next_cur.rowOpen = 1'b0;
                    next_cur.prechLeft = cur.cfg[`DIC_CFG_PRECH];
                    next_cur.state = dic_pkg::PRECH;
                end
            end
            dic_pkg::ROW, dic_pkg::SILENT: begin
                if (ph.stateEnd) begin
                    next_cur.state = dic_pkg::COL1;
                end
            end
            dic_pkg::COL1: begin
                if (ph.stateEnd) begin
                    if (!cur.longP) begin
                        // Short pitch ends here whatever the wait input does
                        next_cur.done = 1'b1;
                        next_cur.state = burstEn ? dic_pkg::IDLE : dic_pkg::PRECH;
                        next_cur.rowOpen = burstEn;
                        next_cur.prechLeft = cur.cfg[`DIC_CFG_PRECH];
                    end else if (!waitN) begin
                        next_cur.state = dic_pkg::WAITST;
                    end else begin
                        next_cur.state = dic_pkg::COL2;
                    end
                end
            end
            dic_pkg::WAITST: begin
                // Second column state repeats while the wait input is low
                if (ph.stateEnd && waitN) begin
                    next_cur.state = dic_pkg::COL2;
                end
            end
            dic_pkg::COL2: begin
                if (ph.stateEnd) begin
                    next_cur.done = 1'b1;
                    next_cur.state = burstEn ? dic_pkg::IDLE : dic_pkg::PRECH;
                    next_cur.rowOpen = burstEn;
                    next_cur.prechLeft = cur.cfg[`DIC_CFG_PRECH];
                end
            end
            dic_pkg::PRECH: begin
                if (ph.stateEnd) begin
                    if (cur.prechLeft) begin
                        next_cur.prechLeft = 1'b0;
                    end else begin
                        next_cur.state = dic_pkg::IDLE;
                    end
                end
            end
            dic_pkg::REFC: begin
                // Column strobe leads; waits only with long CPU read pitch
                if (ph.stateEnd) begin
                    next_cur.state = dic_pkg::REFR;
                    next_cur.waitLeft = cur.pitch[`DIC_PITCH_CPU_RD]
                        ? {cur.pitch[`DIC_PITCH_REFW_HI], cur.pitch[`DIC_PITCH_REFW_LO]} : 2'h0;
                end
            end
            dic_pkg::REFR: begin
                if (ph.stateEnd) begin
                    if (cur.waitLeft != 2'h0) begin
                        next_cur.waitLeft = cur.waitLeft - 2'h1;
                    end else begin
                        next_cur.refAck = 1'b1;
                        next_cur.prechLeft = cur.cfg[`DIC_CFG_PRECH];
                        next_cur.state = dic_pkg::PRECH;
                    end
                end
            end
            default: begin
                next_cur.state = dic_pkg::IDLE;
            end
        endcase

        // Address pins follow the state being entered
        if (cur.cfg[`DIC_CFG_MUX_EN] && next_cur.state == dic_pkg::ROW) begin
            next_cur.dramAddr = {6'h00, rowOf(next_cur.addrLat, shiftSel)};
        end else if (next_cur.state != dic_pkg::IDLE) begin
            next_cur.dramAddr = next_cur.addrLat[21:0];
        end

        // Register bus: write address and data may come in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_cur.awHave = 1'b1;
            next_cur.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_cur.wHave = 1'b1;
            next_cur.wData = s_axi_wdata;
            next_cur.wStrb = s_axi_wstrb;
        end
        if (cur.awHave && cur.wHave) begin
            next_cur.awHave = 1'b0;
            next_cur.wHave = 1'b0;
            next_cur.bValid = 1'b1;
            next_cur.bResp = `DIC_RESP_OKAY;
            case (cur.awAddr)
                `DIC_CFG_OFF: next_cur.cfg = 9'(mergeBytes(32'(cur.cfg), cur.wData, cur.wStrb));
                `DIC_PITCH_OFF: next_cur.pitch = 6'(mergeBytes(32'(cur.pitch), cur.wData, cur.wStrb));
                `DIC_STAT_OFF: next_cur.bResp = `DIC_RESP_OKAY; // Status is read only
                default: next_cur.bResp = `DIC_RESP_SLVERR;
            endcase
        end
        if (cur.bValid && s_axi_bready) begin
            next_cur.bValid = 1'b0;
        end

        // Register bus: reads answer one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            next_cur.rValid = 1'b1;
            next_cur.rResp = `DIC_RESP_OKAY;
            case (s_axi_araddr)
                `DIC_CFG_OFF: next_cur.rData = 32'(cur.cfg);
                `DIC_PITCH_OFF: next_cur.rData = 32'(cur.pitch);
                `DIC_STAT_OFF: next_cur.rData = {cur.rowLatch, 11'h000, cur.rowOpen, 4'(cur.state)};
                default: begin
                    next_cur.rData = 32'h00000000;
                    next_cur.rResp = `DIC_RESP_SLVERR;
                end
            endcase
        end else if (cur.rValid && s_axi_rready) begin
            next_cur.rValid = 1'b0;
        end
    end

    // Register the whole controller state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
            cur.state <= dic_pkg::IDLE;
            cur.cfg <= `DIC_CFG_RESET;
            cur.pitch <= `DIC_PITCH_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Realign the phase whenever the sequencer leaves idle
    assign ph.restart = cur.state == dic_pkg::IDLE && next_cur.state != dic_pkg::IDLE;

    // Column strobe timing: high for the duty part, then low
    assign colState = cur.state == dic_pkg::COL1 || cur.state == dic_pkg::COL2
                      || cur.state == dic_pkg::WAITST;
    always_comb begin
        casOn = 1'b0;
        if (cur.state == dic_pkg::REFC || cur.state == dic_pkg::REFR) begin
            casOn = 1'b1;
        end else if (cur.state == dic_pkg::COL1) begin
            casOn = cur.longP ? (ph.phase >= 8'(TICKS / 2)) : (ph.phase >= highTicks);
        end else if (colState) begin
            casOn = 1'b1;
        end
    end

    // Row strobe low while a row is open, high in precharge and refresh lead
    assign rasN = !(cur.rowOpen || cur.state == dic_pkg::REFR);
    // Byte strobes: dual column strobe or dual write enable on wide space
    assign casHiN = !(casOn && (cur.state == dic_pkg::REFC || cur.state == dic_pkg::REFR
                     || (cur.isWide && !cur.cfg[`DIC_CFG_BYTE] && cur.useUpper)));
    assign casLoN = !(casOn && (!colState || !cur.isWide || cur.cfg[`DIC_CFG_BYTE]
                     || cur.useLower));
    assign wrHiN = !(colState && cur.isWrite && cur.isWide && cur.cfg[`DIC_CFG_BYTE]
                    && cur.useUpper);
    assign wrLoN = !(colState && cur.isWrite && (!cur.isWide || !cur.cfg[`DIC_CFG_BYTE]
                    || cur.useLower));

    // Registered outputs
    assign reqDone = cur.done;
    assign refreshAck = cur.refAck;
    assign dramAddr = cur.dramAddr;
    assign s_axi_awready = !cur.awHave && !cur.bValid;
    assign s_axi_wready = !cur.wHave && !cur.bValid;
    assign s_axi_bvalid = cur.bValid;
    assign s_axi_bresp = cur.bResp;
    assign s_axi_arready = !cur.rValid;
    assign s_axi_rvalid = cur.rValid;
    assign s_axi_rdata = cur.rData;
    assign s_axi_rresp = cur.rResp;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_disabled_refuses: assert property (
        !spaceEn |-> !reqReady) else $error("request taken with DRAM space off");
    a_row_address: assert property (
        cur.state == dic_pkg::ROW && cur.cfg[`DIC_CFG_MUX_EN]
        |-> dramAddr[15:0] == rowOf(cur.addrLat, shiftSel) && dramAddr[21:16] == 6'h00)
        else $error("row address wrong");
    a_col_address: assert property (
        colState |-> dramAddr == cur.addrLat[21:0]) else $error("column address wrong");
    a_short_no_wait: assert property (
        cur.state == dic_pkg::COL1 && ph.stateEnd && !cur.longP
        |=> reqDone && cur.state != dic_pkg::WAITST) else $error("short pitch did not end");
    a_long_wait: assert property (
        cur.state == dic_pkg::COL1 && ph.stateEnd && cur.longP && !waitN
        |=> cur.state == dic_pkg::WAITST) else $error("wait state not inserted");
    a_duty_high: assert property (
        cur.state == dic_pkg::COL1 && !cur.longP && ph.phase < highTicks
        |-> casLoN && casHiN) else $error("column strobe low too early");
    a_prech_len: assert property (
        $rose(cur.state == dic_pkg::PRECH) |-> cur.prechLeft == cur.cfg[`DIC_CFG_PRECH])
        else $error("precharge length wrong");
    a_byte_space: assert property (
        colState && !cur.isWide |-> casHiN && wrHiN) else $error("upper strobe on byte space");
    a_refresh_ras: assert property (
        cur.state == dic_pkg::REFC |-> rasN && !casLoN) else $error("row strobe low at refresh");
    a_silent_write: assert property (
        accept && cur.rowOpen && reqWrite && !reqLong |=> cur.state == dic_pkg::SILENT ##1
        cur.state == dic_pkg::SILENT) else $error("no idle cycle before page write");

endmodule

// ==== hw/dic_regs.svh ====
// Constants of the DRAM interface controller: register offsets, field
// positions, reset values and timing counts.
// Assumes a 25 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH

// Register byte offsets
`define DIC_CFG_OFF 8'h00
`define DIC_PITCH_OFF 8'h04
`define DIC_STAT_OFF 8'h08

// Configuration register fields
`define DIC_CFG_SPACE_EN 0
`define DIC_CFG_MUX_EN 1
`define DIC_CFG_SHIFT_LO 2
`define DIC_CFG_SHIFT_HI 3
`define DIC_CFG_DUTY 4
`define DIC_CFG_PRECH 5
`define DIC_CFG_BYTE 6
`define DIC_CFG_BURST 7
`define DIC_CFG_HOLD 8
`define DIC_CFG_RESET 9'h000

// Pitch register fields
`define DIC_PITCH_CPU_RD 0
`define DIC_PITCH_CPU_WR 1
`define DIC_PITCH_DMA_RD 2
`define DIC_PITCH_DMA_WR 3
`define DIC_PITCH_REFW_LO 4
`define DIC_PITCH_REFW_HI 5
`define DIC_PITCH_RESET 6'h00

// Status register fields
`define DIC_STAT_ROW_OPEN 4
`define DIC_STAT_ROW_LSB 16

// Timing: clocks per bus state and column strobe high duty in percent
`define DIC_TICKS_PER_STATE 20
`define DIC_DUTY_WIDE 50
`define DIC_DUTY_NARROW 35
`define DIC_ROW_BASE_SHIFT 8

// Bus responses
`define DIC_RESP_OKAY 2'h0
`define DIC_RESP_SLVERR 2'h2

`endif

// ==== hw/dic_pkg.sv ====
// Types of the DRAM interface controller.
// Assumes the constants header is compiled alongside.
package dic_pkg;

    // Bus states of the DRAM sequencer
    typedef enum logic [3:0] {
        IDLE, ROW, SILENT, COL1, WAITST, COL2, PRECH, REFC, REFR
    } dic_state_t;

    // State of the sub-state phase divider
    typedef struct packed {
        logic [7:0] count;
    } dic_phase_st_t;

    // Complete state of the controller
    typedef struct packed {
        dic_state_t state;
        logic [8:0] cfg;
        logic [5:0] pitch;
        logic rowOpen;
        logic [15:0] rowLatch;
        logic [23:0] addrLat;
        logic isWrite;
        logic isWide;
        logic useUpper;
        logic useLower;
        logic longP;
        logic prechLeft;
        logic [1:0] waitLeft;
        logic done;
        logic refAck;
        logic [21:0] dramAddr;
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } dic_st_t;

endpackage

// ==== hw/dic_phase_if.sv ====
// Carrier between the sequencer and its phase divider.
// Assumes both ends run on the same clock.
interface dic_phase_if;
    logic restart; // Realign phase to zero
    logic stateEnd; // Last clock of a bus state
    logic [7:0] phase; // Clock index inside the bus state
    modport gen(input restart, output stateEnd, output phase);
    modport user(output restart, input stateEnd, input phase);
endinterface

// ==== hw/dic_phase_gen.sv ====
// Phase divider: splits each bus state into TICKS clocks.
// Assumes restart is a one-cycle pulse from the sequencer.
`include "dic_regs.svh"
module dic_phase_gen #(
    parameter int TICKS = `DIC_TICKS_PER_STATE
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Asynchronous reset, active low
    dic_phase_if.gen ph // Phase outputs
);
    dic_pkg::dic_phase_st_t cur; // Registered state
    dic_pkg::dic_phase_st_t next_cur; // Next state

    // Count within a state, wrap at the end, realign on restart
    always_comb begin
        next_cur = cur;
        if (ph.restart || cur.count == 8'(TICKS - 1)) begin
            next_cur.count = 8'h00;
        end else begin
            next_cur.count = cur.count + 8'h01;
        end
    end

    // Register the divider
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // End pulse ignores restart so no combinational loop forms
    assign ph.stateEnd = (cur.count == 8'(TICKS - 1));
    assign ph.phase = cur.count;

endmodule

// ==== dv/dic_dram_model.sv ====
// Far-side DRAM model: stretches the column phase with the wait line.
// Assumes the controller's active-low strobes on the same clock.
module dic_dram_model (
    input wire logic clk, // System clock
    input wire logic casLoN, // Lower column strobe
    input wire logic [7:0] holdClk, // Wait clocks per access
    output logic waitN // Wait, active low, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt; // Clocks with column strobe low
    // Count restarts per access so each access is stretched alike
    always_ff @(posedge clk) begin
        cnt <= casLoN ? 8'h00 : cnt + 8'h01;
    end
    // Pull-up returns the line high outside the column phase
    assign waitN = casLoN | (cnt >= holdClk);
endmodule

// ==== dv/tb_dic_ctrl.sv ====
// Testbench of the DRAM interface controller.
// Assumes the constants header and a short state of 4 clocks.
`include "dic_regs.svh"
module tb_dic_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4; // Clocks per bus state
    logic clk = 1'b0;
    logic reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reqValid, reqReady, reqWrite, reqDma;
    logic reqWide, reqUpper, reqLower, reqDone, refreshReq, refreshAck, otherAccess, waitN;
    logic rasN, casHiN, casLoN, wrHiN, wrLoN;
    logic [7:0] s_axi_awaddr, s_axi_araddr, holdClk;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [23:0] reqAddr;
    logic [21:0] dramAddr;
    int fails = 0;
    int checksDone = 0;
    dic_ctrl #(.TICKS(T)) dut (.*);
    dic_dram_model model (.*);
    always #20 clk = ~clk;
    // Compare one value, count and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t got %h", $time, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // A used-up wait bound ends the run
    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            fails++;
            $display("CHECK FAILED at %0t wait bound used up", $time);
            test_done();
        end
    endtask
    // Register write, address and data offered together
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (s_axi_bvalid) break;
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        guard(n, 40);
        chk(s_axi_bresp, `DIC_RESP_OKAY);
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask
    // Register read, compared with data bits 29..0 and response
    task automatic axiRd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic ta;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (s_axi_rvalid) break;
            ta = s_axi_arready;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        guard(n, 40);
        chk({s_axi_rresp, s_axi_rdata[29:0]}, {r, d[29:0]});
        @(posedge clk);
        s_axi_rready <= 1'b0;
        // Let an edge pass so a following read does not reassign rready in this step
        @(posedge clk);
    endtask
    // One DRAM access: row then column pins, and its length in clocks
    task automatic acc(input logic [23:0] a, input logic wr, input int len);
        int n;
        reqAddr <= a;
        reqWrite <= wr;
        reqUpper <= wr;
        reqValid <= 1'b1;
        for (n = 0; n < 40 && !reqReady; n++) @(negedge clk);
        guard(n, 40);
        @(posedge clk);
        reqValid <= 1'b0;
        for (n = 0; n < 200 && !reqDone; n++) begin
            @(negedge clk);
            if (n == 0) chk({rasN, dramAddr}, {7'h00, a[23:8]});
            if (n == T) chk(dramAddr, a[21:0]);
            if (n == T) chk({wrHiN, wrLoN}, {1'b1, !wr});
        end
        guard(n, 200);
        // The loop sees the done pulse one falling edge after the closing state
        chk(n - 1, len);
        @(posedge clk);
    endtask
    initial begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
        {reqValid, reqWrite, reqDma, reqWide, reqUpper, refreshReq, otherAccess} <= 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, reqAddr} <= 72'h0;
        s_axi_wstrb <= 4'hF;
        reqLower <= 1'b1;
        holdClk <= 8'h10;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // Shift select stays 00 and duty stays wide, never the reserved or narrow setting
        axiWr(`DIC_CFG_OFF, 32'h00000003);
        axiRd(`DIC_CFG_OFF, 32'h00000003, `DIC_RESP_OKAY);
        axiRd(8'h10, 32'h0, `DIC_RESP_SLVERR);
        $display("register test done");
        acc(24'hA53C7E, 1'b0, 2 * T);
        $display("short access test done");
        axiWr(`DIC_PITCH_OFF, 32'h00000001);
        holdClk <= 8'(2 * T);
        acc(24'h5AC381, 1'b0, 5 * T);
        acc(24'h5AC381, 1'b1, 2 * T);
        $display("long access test done");
        test_done();
    end
endmodule
